// file: verilog/slric_irq_control.sv
// Receive link control registers and error summary interrupt
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module slric_irq_control (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// AHB-Lite register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Per-lane error events from the deframer, one-cycle pulses
	input wire logic [slric_pkg::NUM_LANES-1:0] disparityErr,
	input wire logic [slric_pkg::NUM_LANES-1:0] invalidSymbolErr,
	input wire logic [slric_pkg::NUM_LANES-1:0] strayControlErr,
	// Per-lane failure conditions from the deframer, high while failed
	input wire logic [slric_pkg::NUM_LANES-1:0] laneAlignmentFail,
	input wire logic [slric_pkg::NUM_LANES-1:0] configChecksumFail,
	input wire logic [slric_pkg::NUM_LANES-1:0] frameLockFail,
	input wire logic [slric_pkg::NUM_LANES-1:0] symbolLockFail,
	// Link configuration to the deframer
	output logic [7:0] octetsPerFrame,
	output logic alignmentTestMode,
	output logic thresholdGateEn,
	output logic [7:0] alignmentMultiframeQuarter,
	output logic [7:0] errorCountLimit,
	// Interrupt
	output logic irq_b
);
	import slric_pkg::*;

	// Bus front end to register file
	logic wrStrobe;
	logic [IDX_W-1:0] accIndex;
	logic [7:0] wrData;
	logic [7:0] rdValue;
	// Summary state and counter status
	logic [7:0] summaryMask;
	logic [7:0] summaryFlags;
	logic [7:0] syncFlags;
	logic [7:0] flagClear;
	logic [NUM_LANES-1:0] disparityReached;
	logic [NUM_LANES-1:0] invalidReached;
	logic [NUM_LANES-1:0] strayReached;

	// Next values
	logic [7:0] next_octetsPerFrame;
	logic next_alignmentTestMode;
	logic next_thresholdGateEn;
	logic [7:0] next_alignmentMultiframeQuarter;
	logic [7:0] next_errorCountLimit;
	logic [7:0] next_summaryMask;
	logic [7:0] next_syncFlags;
	logic next_irq_b;

	// Any-lane reductions and the masked interrupt causes
	logic anyDisparity;
	logic anyInvalid;
	logic anyStray;
	logic anyLaneAlign;
	logic anyChecksum;
	logic anyFrameLock;
	logic anySymbolLock;
	logic [7:0] maskedCause;

	function automatic logic writeHit(input logic strobe, input logic [IDX_W-1:0] idx,
		input logic [IDX_W-1:0] target);
		writeHit = strobe && idx == target;
	endfunction

	function automatic logic legalOctets(input logic [7:0] value);
		legalOctets = value == OCTETS_ONE || value == OCTETS_TWO || value == OCTETS_FOUR;
	endfunction

	slric_ahb_slave u_bus (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.wrStrobe(wrStrobe),
		.accIndex(accIndex),
		.wrData(wrData),
		.rdValue(rdValue)
	);

	// Write-one-to-clear strobes; reserved bit 4 has nothing behind it
	// Bits 7..5 also zero the counters behind them
	always_comb begin
		flagClear = 8'h00;
		if (writeHit(wrStrobe, accIndex, IDX_ERROR_FLAG_CLEAR)) begin
			flagClear = wrData & SUMMARY_USED;
		end
	end

	// Three counters per lane, one per error kind
	genvar lane;
	generate
		for (lane = 0; lane < NUM_LANES; lane++) begin : g_lane
			slric_err_counter u_disparity (
				.sys_clk(sys_clk),
				.rst_b(rst_b),
				.errPulse(disparityErr[lane]),
				.clear(flagClear[BIT_DISPARITY]),
				.limit(errorCountLimit),
				.reached(disparityReached[lane])
			);
			slric_err_counter u_invalid (
				.sys_clk(sys_clk),
				.rst_b(rst_b),
				.errPulse(invalidSymbolErr[lane]),
				.clear(flagClear[BIT_INVALID_SYMBOL]),
				.limit(errorCountLimit),
				.reached(invalidReached[lane])
			);
			slric_err_counter u_stray (
				.sys_clk(sys_clk),
				.rst_b(rst_b),
				.errPulse(strayControlErr[lane]),
				.clear(flagClear[BIT_STRAY_CONTROL]),
				.limit(errorCountLimit),
				.reached(strayReached[lane])
			);
		end
	endgenerate

	// Per-lane detail stays in the counters; only the OR reaches software
	assign anyDisparity = |disparityReached;
	assign anyInvalid = |invalidReached;
	assign anyStray = |strayReached;
	assign anyLaneAlign = |laneAlignmentFail;
	assign anyChecksum = |configChecksumFail;
	assign anyFrameLock = |frameLockFail;
	assign anySymbolLock = |symbolLockFail;

	// Summary vector; bit 4 stays zero
	always_comb begin
		summaryFlags = syncFlags;
		summaryFlags[BIT_DISPARITY] = anyDisparity;
		summaryFlags[BIT_INVALID_SYMBOL] = anyInvalid;
		summaryFlags[BIT_STRAY_CONTROL] = anyStray;
		summaryFlags[BIT_SUMMARY_RSVD] = 1'b0;
	end

	// Sticky link failure flags; a failure in the clearing cycle wins
	always_comb begin
		next_syncFlags = syncFlags & ~flagClear;
		if (anyLaneAlign) begin
			next_syncFlags[BIT_LANE_ALIGN] = 1'b1;
		end
		if (anyChecksum) begin
			next_syncFlags[BIT_CHECKSUM] = 1'b1;
		end
		if (anyFrameLock) begin
			next_syncFlags[BIT_FRAME_LOCK] = 1'b1;
		end
		if (anySymbolLock) begin
			next_syncFlags[BIT_SYMBOL_LOCK] = 1'b1;
		end
		// Bits 7..5 live in the counters, bit 4 is reserved
		next_syncFlags = next_syncFlags & 8'h0f;
	end

	// Configuration registers
	always_comb begin
		next_octetsPerFrame = octetsPerFrame;
		next_alignmentTestMode = alignmentTestMode;
		next_thresholdGateEn = thresholdGateEn;
		next_alignmentMultiframeQuarter = alignmentMultiframeQuarter;
		next_errorCountLimit = errorCountLimit;
		// Illegal frame sizes are dropped so the deframer never sees one
		if (writeHit(wrStrobe, accIndex, IDX_FRAME_OCTET_COUNT) && legalOctets(wrData)) begin
			next_octetsPerFrame = wrData;
		end
		if (writeHit(wrStrobe, accIndex, IDX_LINK_TEST_CONTROL)) begin
			next_alignmentTestMode = wrData[BIT_ALIGN_TEST_MODE];
			next_thresholdGateEn = wrData[BIT_THRESHOLD_GATE];
		end
		// Zero would mean an empty alignment sequence
		if (writeHit(wrStrobe, accIndex, IDX_ALIGN_MF_COUNT) && wrData != 8'h00) begin
			next_alignmentMultiframeQuarter = wrData;
		end
		if (writeHit(wrStrobe, accIndex, IDX_ERROR_COUNT_LIMIT)) begin
			next_errorCountLimit = wrData;
		end
	end

	// Mask write; the mask is write-only and never read back
	always_comb begin
		next_summaryMask = summaryMask;
		if (writeHit(wrStrobe, accIndex, IDX_ERROR_SUMMARY)) begin
			next_summaryMask = wrData & SUMMARY_USED;
		end
	end

	// Read mux; the summary address returns flags, never the mask
	always_comb begin
		case (accIndex)
			IDX_FRAME_OCTET_COUNT: rdValue = octetsPerFrame;
			IDX_LINK_TEST_CONTROL: begin
				rdValue = 8'h00;
				rdValue[BIT_ALIGN_TEST_MODE] = alignmentTestMode;
				rdValue[BIT_THRESHOLD_GATE] = thresholdGateEn;
			end
			IDX_ALIGN_MF_COUNT: rdValue = alignmentMultiframeQuarter;
			IDX_ERROR_SUMMARY: rdValue = summaryFlags;
			IDX_ERROR_COUNT_LIMIT: rdValue = errorCountLimit;
			default: rdValue = 8'h00;
		endcase
	end

	// One gate per summary bit except reserved bit 4; registered so a mask write cannot glitch the pin
	always_comb begin
		maskedCause = 8'h00;
		maskedCause[BIT_DISPARITY] = summaryFlags[BIT_DISPARITY] &
			summaryMask[BIT_DISPARITY];
		maskedCause[BIT_INVALID_SYMBOL] = summaryFlags[BIT_INVALID_SYMBOL] &
			summaryMask[BIT_INVALID_SYMBOL];
		maskedCause[BIT_STRAY_CONTROL] = summaryFlags[BIT_STRAY_CONTROL] &
			summaryMask[BIT_STRAY_CONTROL];
		maskedCause[BIT_LANE_ALIGN] = summaryFlags[BIT_LANE_ALIGN] &
			summaryMask[BIT_LANE_ALIGN];
		maskedCause[BIT_CHECKSUM] = summaryFlags[BIT_CHECKSUM] &
			summaryMask[BIT_CHECKSUM];
		maskedCause[BIT_FRAME_LOCK] = summaryFlags[BIT_FRAME_LOCK] &
			summaryMask[BIT_FRAME_LOCK];
		maskedCause[BIT_SYMBOL_LOCK] = summaryFlags[BIT_SYMBOL_LOCK] &
			summaryMask[BIT_SYMBOL_LOCK];
		next_irq_b = ~|maskedCause;
	end

	// Link configuration registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			octetsPerFrame <= RST_FRAME_OCTET_COUNT;
			alignmentTestMode <= 1'b0;
			thresholdGateEn <= 1'b0;
			alignmentMultiframeQuarter <= RST_ALIGN_MF_COUNT;
			errorCountLimit <= RST_ERROR_COUNT_LIMIT;
		end else begin
			octetsPerFrame <= next_octetsPerFrame;
			alignmentTestMode <= next_alignmentTestMode;
			thresholdGateEn <= next_thresholdGateEn;
			alignmentMultiframeQuarter <= next_alignmentMultiframeQuarter;
			errorCountLimit <= next_errorCountLimit;
		end
	end

	// Mask and sticky link failures
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			summaryMask <= RST_SUMMARY;
			syncFlags <= RST_SUMMARY;
		end else begin
			summaryMask <= next_summaryMask;
			syncFlags <= next_syncFlags;
		end
	end

	// Interrupt pin, idle high
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_b <= 1'b1;
		end else begin
			irq_b <= next_irq_b;
		end
	end
endmodule // slric_irq_control

// file: verilog/slric_pkg.sv
// Constants shared by the link receive control and error interrupt block
package slric_pkg;
	localparam int NUM_LANES = 4;
	localparam int IDX_W = 12;
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_FRAME_OCTET_COUNT = 12'h476;
	localparam logic [IDX_W-1:0] IDX_LINK_TEST_CONTROL = 12'h477;
	localparam logic [IDX_W-1:0] IDX_ALIGN_MF_COUNT = 12'h478;
	localparam logic [IDX_W-1:0] IDX_ERROR_SUMMARY = 12'h47a;
	localparam logic [IDX_W-1:0] IDX_ERROR_COUNT_LIMIT = 12'h47c;
	localparam logic [IDX_W-1:0] IDX_ERROR_FLAG_CLEAR = 12'h47d;
	// Reset values
	localparam logic [7:0] RST_FRAME_OCTET_COUNT = 8'h01;
	localparam logic [7:0] RST_ALIGN_MF_COUNT = 8'h01;
	localparam logic [7:0] RST_ERROR_COUNT_LIMIT = 8'hff;
	localparam logic [7:0] RST_SUMMARY = 8'h00;
	// Legal octets-per-frame settings
	localparam logic [7:0] OCTETS_ONE = 8'h01;
	localparam logic [7:0] OCTETS_TWO = 8'h02;
	localparam logic [7:0] OCTETS_FOUR = 8'h04;
	// Link test control fields
	localparam int BIT_ALIGN_TEST_MODE = 7;
	localparam int BIT_THRESHOLD_GATE = 3;
	// Summary flag and mask bit positions
	localparam int BIT_DISPARITY = 7;
	localparam int BIT_INVALID_SYMBOL = 6;
	localparam int BIT_STRAY_CONTROL = 5;
	localparam int BIT_SUMMARY_RSVD = 4;
	localparam int BIT_LANE_ALIGN = 3;
	localparam int BIT_CHECKSUM = 2;
	localparam int BIT_FRAME_LOCK = 1;
	localparam int BIT_SYMBOL_LOCK = 0;
	localparam logic [7:0] SUMMARY_USED = 8'hef;
	// Error counter saturation value
	localparam logic [7:0] COUNT_MAX = 8'hff;
	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	typedef enum logic [2:0] {
		SLRIC_IDLE = 3'b001,
		SLRIC_RD_WAIT = 3'b010,
		SLRIC_RD_DONE = 3'b100
	} slric_bus_state_t;
endpackage

// file: verilog/slric_err_counter.sv
// Per-lane error counter with sticky threshold-reached flag
`timescale 1ns/1ps
module slric_err_counter (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Error events and control
	input wire logic errPulse,
	input wire logic clear,
	input wire logic [7:0] limit,
	// Status
	output logic reached
);
	import slric_pkg::*;

	logic [7:0] count;
	logic [7:0] next_count;
	logic next_reached;

	always_comb begin
		next_count = clear ? 8'h00 : count;
		// Saturate so a long error burst never wraps below the limit
		if (errPulse && next_count != COUNT_MAX) begin
			next_count = next_count + 8'h01;
		end
		// A zero limit would fire with no errors, so one error is required
		next_reached = (reached && !clear) || (next_count != 8'h00 && next_count >= limit);
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= 8'h00;
			reached <= 1'b0;
		end else begin
			count <= next_count;
			reached <= next_reached;
		end
	end
endmodule // slric_err_counter

// file: verilog/slric_ahb_slave.sv
// AHB-Lite slave front end: address capture, read wait state, write strobe
`timescale 1ns/1ps
module slric_ahb_slave (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// AHB-Lite
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Register side
	output logic wrStrobe,
	output logic [slric_pkg::IDX_W-1:0] accIndex,
	output logic [7:0] wrData,
	input wire logic [7:0] rdValue
);
	import slric_pkg::*;

	slric_bus_state_t state;
	slric_bus_state_t next_state;
	logic pendWrite;
	logic next_pendWrite;
	logic [IDX_W-1:0] next_accIndex;
	logic [31:0] next_hrdata;
	logic take;
	logic legal;

	assign take = hsel && hready && htrans == HTRANS_NONSEQ;
	// Anything off the word grid or above the map is unmapped
	assign legal = haddr[31:14] == 18'h0 && haddr[1:0] == 2'h0 && hsize == HSIZE_WORD;
	assign hresp = 1'b0;
	assign hreadyout = state != SLRIC_RD_WAIT;
	assign wrStrobe = pendWrite;
	assign wrData = hwdata[7:0];

	always_comb begin
		next_state = SLRIC_IDLE;
		next_pendWrite = 1'b0;
		next_accIndex = accIndex;
		next_hrdata = hrdata;
		case (state)
			SLRIC_RD_WAIT: begin
				// Read sampled one cycle late so a preceding write is visible
				next_hrdata = {24'h0, rdValue};
				next_state = SLRIC_RD_DONE;
			end
			SLRIC_IDLE, SLRIC_RD_DONE: begin
				if (take) begin
					next_accIndex = legal ? haddr[13:2] : '0;
					next_pendWrite = hwrite && legal;
					next_state = hwrite ? SLRIC_IDLE : SLRIC_RD_WAIT;
				end
			end
			default: next_state = SLRIC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= SLRIC_IDLE;
			pendWrite <= 1'b0;
			accIndex <= '0;
			hrdata <= 32'h0;
		end else begin
			state <= next_state;
			pendWrite <= next_pendWrite;
			accIndex <= next_accIndex;
			hrdata <= next_hrdata;
		end
	end
endmodule // slric_ahb_slave

// file: dv/slric_irq_control_monitor.sv
// Checker for the receive control and error interrupt block
`timescale 1ns/1ps
module slric_irq_control_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Lane events
	input wire logic [3:0] disparityErr,
	input wire logic [3:0] invalidSymbolErr,
	input wire logic [3:0] strayControlErr,
	input wire logic [3:0] laneAlignmentFail,
	input wire logic [3:0] configChecksumFail,
	input wire logic [3:0] frameLockFail,
	input wire logic [3:0] symbolLockFail,
	// Configuration and interrupt
	input wire logic [7:0] octetsPerFrame,
	input wire logic alignmentTestMode,
	input wire logic thresholdGateEn,
	input wire logic [7:0] alignmentMultiframeQuarter,
	input wire logic [7:0] errorCountLimit,
	input wire logic irq_b
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic wrTaken;
	logic rdTaken;
	logic cause;
	assign wrTaken = hsel && hready && htrans == 2'h2 && hwrite;
	assign rdTaken = hsel && hready && htrans == 2'h2 && !hwrite;
	assign cause = wrTaken || |{disparityErr, invalidSymbolErr, strayControlErr,
		laneAlignmentFail, configChecksumFail, frameLockFail, symbolLockFail};
	reset_vals_a: assert property ($rose(rst_b) |-> octetsPerFrame == 8'h01 &&
		!alignmentTestMode && alignmentMultiframeQuarter == 8'h01 && errorCountLimit == 8'hff)
		else $error("config outputs not at reset values");
	octets_legal_a: assert property (octetsPerFrame inside {8'h01, 8'h02, 8'h04})
		else $error("octets per frame illegal");
	mf_nonzero_a: assert property (alignmentMultiframeQuarter != 8'h00)
		else $error("multiframe count zero");
	octets_cause_a: assert property (!$stable(octetsPerFrame) |-> $past(wrTaken, 2))
		else $error("octets changed without a write");
	ctrl_cause_a: assert property (!$stable({alignmentTestMode, thresholdGateEn,
		alignmentMultiframeQuarter, errorCountLimit}) |-> $past(wrTaken, 2))
		else $error("control changed without a write");
	irq_set_a: assert property ($fell(irq_b) |-> $past(cause) || $past(cause, 2)
		|| $past(cause, 3)) else $error("interrupt fell without cause");
	irq_release_a: assert property ($rose(irq_b) |-> $past(wrTaken) || $past(wrTaken, 2)
		|| $past(wrTaken, 3)) else $error("interrupt rose without a write");
	read_wait_a: assert property (rdTaken |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_nowait_a: assert property (wrTaken |=> hreadyout)
		else $error("write stalled");
	bus_okay_a: assert property (!hresp && hrdata[31:8] == 24'h0)
		else $error("response or upper read data wrong");
	irq_low_c: cover property ($fell(irq_b));
	read_c: cover property (rdTaken);
	octets_c: cover property (!$stable(octetsPerFrame));
endmodule // slric_irq_control_monitor
bind slric_irq_control slric_irq_control_monitor mon (.*);

// file: dv/slric_lane_model.sv
// Far-end lane model: per-lane error pulses and failure levels
`timescale 1ns/1ps
module slric_lane_model (
	// Clock
	input wire logic sys_clk,
	// Lane events toward the receiver
	output logic [3:0] disparityErr,
	output logic [3:0] invalidSymbolErr,
	output logic [3:0] strayControlErr,
	output logic [3:0] laneAlignmentFail,
	output logic [3:0] configChecksumFail,
	output logic [3:0] frameLockFail,
	output logic [3:0] symbolLockFail
);
	initial begin
		{disparityErr, invalidSymbolErr, strayControlErr} = '0;
		{laneAlignmentFail, configChecksumFail, frameLockFail, symbolLockFail} = '0;
	end
	// Source picked by the summary bit it should raise; errors counted per lane
	task automatic drive(input int bitPos, input int lane, input logic lvl);
		@(posedge sys_clk);
		case (bitPos)
			7: disparityErr[lane] <= lvl;
			6: invalidSymbolErr[lane] <= lvl;
			5: strayControlErr[lane] <= lvl;
			3: laneAlignmentFail[lane] <= lvl;
			2: configChecksumFail[lane] <= lvl;
			1: frameLockFail[lane] <= lvl;
			default: symbolLockFail[lane] <= lvl;
		endcase
	endtask
endmodule // slric_lane_model

// file: dv/tb_top.sv
// Testbench for the receive control and error interrupt block
`timescale 1ns/1ps
module tb_top;
	import slric_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic hready, hreadyout, hresp;
	logic [31:0] hrdata;
	logic [3:0] disparityErr, invalidSymbolErr, strayControlErr, laneAlignmentFail;
	logic [3:0] configChecksumFail, frameLockFail, symbolLockFail;
	logic [7:0] octetsPerFrame, alignmentMultiframeQuarter, errorCountLimit;
	logic alignmentTestMode, thresholdGateEn, irq_b;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [7:0] rd;
	assign hready = hreadyout;
	always #4 sys_clk = ~sys_clk;
	slric_irq_control dut (.*);
	slric_lane_model lanes (.*);
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chkVal(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chkPin(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask
	// Ready judged before the edge, so flop updates at the edge cannot race
	task automatic waitRdy();
		logic ok;
		do begin
			@(negedge sys_clk);
			ok = hreadyout;
			rd = hrdata[7:0];
			@(posedge sys_clk);
		end while (ok !== 1'b1);
	endtask
	task automatic bus(input logic [IDX_W-1:0] idx, input logic wr, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {18'h0, idx, 2'h0};
		hwrite <= wr;
		waitRdy();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		waitRdy();
	endtask
	task automatic readChk(input logic [IDX_W-1:0] idx, input logic [7:0] exp, input string what);
		bus(idx, 1'b0, 8'h00);
		chkVal(what, exp, rd);
	endtask
	task automatic testReset();
		readChk(IDX_FRAME_OCTET_COUNT, 8'h01, "octets");
		readChk(IDX_LINK_TEST_CONTROL, 8'h00, "test control");
		readChk(IDX_ALIGN_MF_COUNT, 8'h01, "multiframe");
		readChk(IDX_ERROR_COUNT_LIMIT, 8'hff, "limit");
		bus(IDX_ERROR_SUMMARY, 1'b1, 8'hff);
		readChk(IDX_ERROR_SUMMARY, 8'h00, "summary");
		chkPin("irq idle", 1'b1, irq_b);
		$display("reset test done");
	endtask
	task automatic testOctets();
		logic [7:0] vals [5] = '{8'h02, 8'h03, 8'h04, 8'h00, 8'h01};
		logic [7:0] exp [5] = '{8'h02, 8'h02, 8'h04, 8'h04, 8'h01};
		for (int i = 0; i < 5; i++) begin
			bus(IDX_FRAME_OCTET_COUNT, 1'b1, vals[i]);
			readChk(IDX_FRAME_OCTET_COUNT, exp[i], "octets");
			chkVal("octets pin", exp[i], octetsPerFrame);
		end
		$display("octets test done");
	endtask
	task automatic testCtrl();
		bus(IDX_LINK_TEST_CONTROL, 1'b1, 8'hff);
		readChk(IDX_LINK_TEST_CONTROL, 8'h88, "test control");
		chkPin("test mode", 1'b1, alignmentTestMode);
		chkPin("gate", 1'b1, thresholdGateEn);
		bus(IDX_LINK_TEST_CONTROL, 1'b1, 8'h08);
		readChk(IDX_LINK_TEST_CONTROL, 8'h08, "test mode off");
		chkPin("test mode pin", 1'b0, alignmentTestMode);
		bus(IDX_ALIGN_MF_COUNT, 1'b1, 8'h00);
		readChk(IDX_ALIGN_MF_COUNT, 8'h01, "multiframe zero");
		bus(IDX_ALIGN_MF_COUNT, 1'b1, 8'h06);
		readChk(IDX_ALIGN_MF_COUNT, 8'h06, "multiframe");
		chkVal("multiframe pin", 8'h06, alignmentMultiframeQuarter);
		bus(12'h479, 1'b1, 8'h5a);
		readChk(12'h479, 8'h00, "unmapped");
		$display("control test done");
	endtask
	task automatic testFlags();
		int bits [7] = '{7, 6, 5, 3, 2, 1, 0};
		int b;
		bus(IDX_ERROR_COUNT_LIMIT, 1'b1, 8'h02);
		readChk(IDX_ERROR_COUNT_LIMIT, 8'h02, "limit");
		chkVal("limit pin", 8'h02, errorCountLimit);
		for (int i = 0; i < 7; i++) begin
			b = bits[i];
			bus(IDX_ERROR_SUMMARY, 1'b1, 8'h00);
			lanes.drive(b, i % 4, 1'b1);
			if (b > 4) begin
				lanes.drive(b, i % 4, 1'b0);
				readChk(IDX_ERROR_SUMMARY, 8'h00, "below limit");
				lanes.drive(b, i % 4, 1'b1);
				lanes.drive(b, i % 4, 1'b0);
			end
			readChk(IDX_ERROR_SUMMARY, 8'h01 << b, "flags");
			chkPin("irq masked", 1'b1, irq_b);
			bus(IDX_ERROR_SUMMARY, 1'b1, (8'h01 << b) | 8'h10);
			readChk(IDX_ERROR_SUMMARY, 8'h01 << b, "flags held");
			chkPin("irq", 1'b0, irq_b);
			if (b < 4) lanes.drive(b, i % 4, 1'b0);
			bus(IDX_ERROR_FLAG_CLEAR, 1'b1, 8'h01 << b);
			readChk(IDX_ERROR_SUMMARY, 8'h00, "cleared");
			chkPin("irq released", 1'b1, irq_b);
		end
		// A failure still present during the clear keeps its flag
		lanes.drive(3, 0, 1'b1);
		bus(IDX_ERROR_FLAG_CLEAR, 1'b1, 8'h08);
		readChk(IDX_ERROR_SUMMARY, 8'h08, "set over clear");
		lanes.drive(3, 0, 1'b0);
		bus(IDX_ERROR_FLAG_CLEAR, 1'b1, 8'h08);
		readChk(IDX_ERROR_SUMMARY, 8'h00, "clear after drop");
		readChk(IDX_ERROR_FLAG_CLEAR, 8'h00, "clear reads zero");
		$display("flags test done");
	endtask
	// Whole run is a few hundred cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			report_and_stop();
		end
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		testReset();
		testOctets();
		testCtrl();
		testFlags();
		report_and_stop();
	end
endmodule // tb_top
